// [core/adcs_sequencer.sv]
// Successive-approximation conversion sequencer with APB register file.
//
// Local design decisions: the APB register port and the placing of the registers.
`timescale 1ns/1ns
`include "adcs_defines.svh"

// Functional notes
// - Clock from divided system clock or RC
// - Divider code applies only with system clock
// - Control logic advances on selected clock
// - Done flag set after every conversion
// - Done flag cleared only by software
// - Enabled done event raises wake request
// - In sleep convert only on RC clock
// - Result read left or right justified
// - Result writes stored right justified
// - Convert only while module is on
// - Start from software, trigger or repeat
// - Copy old result to previous first
// - Completion clears request, sets flags, accumulates
// - Error and threshold per conversion or pair
// - Computation lags the done flag
// - Request cleared midway stores partial result
// - Reset clears registers and abandons conversion
// - Trigger rising edge sets request bit
// - Sleep trigger on system clock waits
// - Sleep completion without irq powers down
module adcs_sequencer (
    input  wire logic        clk_sys,
    input  wire logic        sys_rst,
    input  wire logic        clkEn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        extTrig,
    input  wire logic        rcOscIn,
    input  wire logic        cmpOut,
    input  wire logic        sleepMode,
    output logic             sampleHold,
    output logic [11:0]      dacCode,
    output logic             wakeReq,
    output logic             powerDown
);

    adcs_pkg::adcs_regs_t st_q;
    adcs_pkg::adcs_regs_t st_d;
    logic        tick;
    logic        runOk;
    logic        trigRise;
    logic        setup;
    logic        wrAcc;
    logic        swGoWr;
    logic        finish;
    logic        mathDue;
    logic        lastBit;
    logic [11:0] partial;
    logic [11:0] resolved;
    logic [11:0] newRes;
    logic [12:0] diff;

    // ======================================================================
    // Conversion clock
    adcs_tick_gen u_tick (
        .clk_sys (clk_sys),
        .sys_rst (sys_rst),
        .clkEn   (clkEn),
        .clkSel  (st_q.cs),
        .divCode (st_q.clkDiv),
        .rcLevel (st_q.rcSync[1]),
        .tick    (tick)
    );

    // ======================================================================
    // Partial result: unresolved bits repeat the last resolved bit
    assign lastBit = (st_q.bitIdx == `ADCS_MSB_IDX) ? 1'b0 :
                     st_q.dac[st_q.bitIdx + 4'h1];
    genvar gi;
    generate
        for (gi = 0; gi < 12; gi = gi + 1) begin : g_part
            assign partial[gi] = (4'(gi) > st_q.bitIdx) ? st_q.dac[gi] :
                                 lastBit;
        end
    endgenerate

    assign runOk    = st_q.on & ~st_q.powerDown &
                      ~(sleepMode & ~st_q.cs);
    assign trigRise = st_q.trigSync[1] & ~st_q.trigSync[2];
    assign setup    = psel & ~penable;
    assign wrAcc    = psel & penable & st_q.pready & pwrite & ~st_q.pslverr;
    assign swGoWr   = wrAcc & (paddr == `ADCS_OFF_CTRL);
    assign mathDue  = ~st_q.double_sample_enable | st_q.pairOdd;
    assign diff     = {1'b0, st_q.res} - {1'b0, st_q.setpoint};

    always_comb begin
        st_d     = st_q;
        finish   = 1'b0;
        newRes   = 12'h000;
        resolved = st_q.dac;
        resolved[st_q.bitIdx] = st_q.cmpSync[1];

        // ==================================================================
        // Synchronisers for pins
        st_d.trigSync = {st_q.trigSync[1:0], extTrig};
        st_d.cmpSync  = {st_q.cmpSync[0], cmpOut};
        st_d.rcSync   = {st_q.rcSync[0], rcOscIn};

        // ==================================================================
        // APB slave: data and answer registered in setup, ready in access
        st_d.pready  = setup;
        st_d.pslverr = 1'b0;
        if (setup) begin
            st_d.prdata = 32'h0000_0000;
            case (paddr)
                `ADCS_OFF_CTRL: begin
                    st_d.prdata[8:0] = {st_q.trigEn, st_q.irqEn, st_q.double_sample_enable,
                                        st_q.previous_source_select, st_q.repeat_enable, st_q.result_justify_select,
                                        st_q.cs, st_q.go, st_q.on};
                end
                `ADCS_OFF_CLKDIV: begin
                    st_d.prdata[6:0] = st_q.clkDiv;
                end
                `ADCS_OFF_STATUS: begin
                    st_d.prdata[5:0] = {st_q.powerDown, st_q.trigPend,
                                        st_q.state != adcs_pkg::ADCS_IDLE,
                                        st_q.mathFlag, st_q.thrFlag,
                                        st_q.doneFlag};
                end
                `ADCS_OFF_RESULT: begin
                    if (st_q.result_justify_select) begin
                        st_d.prdata[11:0] = st_q.res;
                    end else begin
                        st_d.prdata[15:0] = {st_q.res, 4'h0};
                    end
                end
                `ADCS_OFF_PREV: begin
                    st_d.prdata[11:0] = st_q.prev;
                end
                `ADCS_OFF_ACC: begin
                    st_d.prdata[17:0] = st_q.acc;
                end
                `ADCS_OFF_SETPOINT: begin
                    st_d.prdata[11:0] = st_q.setpoint;
                end
                `ADCS_OFF_THRESH: begin
                    st_d.prdata[12:0] = st_q.thresh;
                end
                `ADCS_OFF_ERROR: begin
                    st_d.prdata = {{19{st_q.err[12]}}, st_q.err};
                end
                default: begin
                    st_d.pslverr = 1'b1;
                end
            endcase
        end
        if (wrAcc) begin
            case (paddr)
                `ADCS_OFF_CTRL: begin
                    st_d.on     = pwdata[`ADCS_CTRL_ON];
                    st_d.go     = pwdata[`ADCS_CTRL_GO];
                    st_d.cs     = pwdata[`ADCS_CTRL_CS];
                    st_d.result_justify_select    = pwdata[`ADCS_CTRL_FRM];
                    st_d.repeat_enable   = pwdata[`ADCS_CTRL_REPEAT_ENABLE];
                    st_d.previous_source_select   = pwdata[`ADCS_CTRL_PREVIOUS_SOURCE_SELECT];
                    st_d.double_sample_enable   = pwdata[`ADCS_CTRL_DOUBLE_SAMPLE_ENABLE];
                    st_d.irqEn  = pwdata[`ADCS_CTRL_IRQEN];
                    st_d.trigEn = pwdata[`ADCS_CTRL_TRIGEN];
                end
                `ADCS_OFF_CLKDIV: begin
                    st_d.clkDiv = pwdata[6:0];
                end
                `ADCS_OFF_STATUS: begin
                    // Write one to clear; hardware sets below win.
                    if (pwdata[`ADCS_ST_DONE]) begin
                        st_d.doneFlag = 1'b0;
                    end
                    if (pwdata[`ADCS_ST_THR]) begin
                        st_d.thrFlag = 1'b0;
                    end
                    if (pwdata[`ADCS_ST_MATH]) begin
                        st_d.mathFlag = 1'b0;
                    end
                end
                `ADCS_OFF_RESULT: begin
                    st_d.res = pwdata[11:0];
                end
                `ADCS_OFF_SETPOINT: begin
                    st_d.setpoint = pwdata[11:0];
                end
                `ADCS_OFF_THRESH: begin
                    st_d.thresh = pwdata[12:0];
                end
                default: begin
                end
            endcase
        end
        if (!st_q.double_sample_enable) begin
            st_d.pairOdd = 1'b0;
        end

        // ==================================================================
        // Sequencer, advanced on conversion clock ticks; switching off returns it to idle without waiting for a tick
        case (st_q.state)
            adcs_pkg::ADCS_IDLE: begin
                st_d.bitIdx = `ADCS_MSB_IDX;
                st_d.dac    = 12'h000;
                if (tick && runOk && st_q.go) begin
                    st_d.state      = adcs_pkg::ADCS_SAMPLE;
                    st_d.sampleHold = 1'b1;
                end
            end
            adcs_pkg::ADCS_SAMPLE: begin
                if (!st_q.on) begin
                    st_d.state      = adcs_pkg::ADCS_IDLE;
                    st_d.sampleHold = 1'b0;
                end else if (tick && runOk) begin
                    st_d.sampleHold = 1'b0;
                    if (!st_q.go) begin
                        finish = 1'b1;
                        newRes = partial;
                    end else begin
                        st_d.state = adcs_pkg::ADCS_CONV;
                        st_d.dac   = `ADCS_MSB_TRIAL;
                    end
                end
            end
            adcs_pkg::ADCS_CONV: begin
                if (!st_q.on) begin
                    st_d.state = adcs_pkg::ADCS_IDLE;
                end else if (tick && runOk) begin
                    if (!st_q.go) begin
                        finish = 1'b1;
                        newRes = partial;
                    end else if (st_q.bitIdx == 4'h0) begin
                        finish = 1'b1;
                        newRes = resolved;
                    end else begin
                        st_d.bitIdx = st_q.bitIdx - 4'h1;
                        st_d.dac    = resolved |
                                      (12'h001 << (st_q.bitIdx - 4'h1));
                    end
                end
            end
            default: begin
                st_d.state = adcs_pkg::ADCS_IDLE;
            end
        endcase

        // ==================================================================
        // Completion, also reached by an abort with a partial result
        if (!sleepMode) begin
            st_d.powerDown = 1'b0;
        end
        if (finish) begin
            st_d.state = adcs_pkg::ADCS_IDLE;
            if (st_q.previous_source_select) begin
                st_d.prev = st_q.res;
            end
            st_d.res      = newRes;
            st_d.doneFlag = 1'b1;
            st_d.mathFlag = 1'b1;
            st_d.acc      = st_q.acc + {6'h00, newRes};
            if (!st_q.repeat_enable && !swGoWr) begin
                st_d.go = 1'b0;
            end
            if (st_q.double_sample_enable) begin
                st_d.pairOdd = ~st_q.pairOdd;
            end
            if (mathDue) begin
                st_d.mathPend = 1'b1;
            end
            if (sleepMode && !st_q.irqEn) begin
                st_d.powerDown = 1'b1;
            end
        end

        // Error and threshold one cycle after the result is stored.
        if (st_q.mathPend) begin
            st_d.mathPend = 1'b0;
            st_d.err      = diff;
            if ($signed(diff) > $signed(st_q.thresh)) begin
                st_d.thrFlag = 1'b1;
            end
        end

        // ==================================================================
        // External trigger, held back while sleeping on the system clock
        if (st_q.trigEn && trigRise) begin
            if (sleepMode && !st_q.cs) begin
                st_d.trigPend = 1'b1;
            end else begin
                st_d.go = 1'b1;
            end
        end
        if (st_q.trigPend && !sleepMode) begin
            st_d.trigPend = 1'b0;
            st_d.go       = 1'b1;
        end

        st_d.wakeReq = st_q.irqEn & st_q.doneFlag;
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            st_q          <= '0;
            st_q.state    <= adcs_pkg::ADCS_IDLE;
            st_q.bitIdx   <= `ADCS_MSB_IDX;
            st_q.clkDiv   <= `ADCS_CLKDIV_RST;
            st_q.setpoint <= `ADCS_SETPT_RST;
            st_q.thresh   <= `ADCS_THRESH_RST;
        end else if (clkEn) begin
            st_q <= st_d;
        end
    end

    assign prdata     = st_q.prdata;
    assign pready     = st_q.pready;
    assign pslverr    = st_q.pslverr;
    assign sampleHold = st_q.sampleHold;
    assign dacCode    = st_q.dac;
    assign wakeReq    = st_q.wakeReq;
    assign powerDown  = st_q.powerDown;

    // ======================================================================
    // Checks
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (sys_rst);

    done_sticky_a: assert property (clkEn && st_q.doneFlag &&
        !(wrAcc && paddr == `ADCS_OFF_STATUS && pwdata[0])
        |=> st_q.doneFlag) else $error("done flag lost");
    done_set_a: assert property (clkEn && finish
        |=> st_q.doneFlag) else $error("done flag not set");
    go_clear_a: assert property (clkEn && finish && !st_q.repeat_enable &&
        !swGoWr && !trigRise && !st_q.trigPend
        |=> !st_q.go) else $error("request not cleared");
    prev_copy_a: assert property (clkEn && finish && st_q.previous_source_select
        |=> st_q.prev == $past(st_q.res)) else $error("previous wrong");
    off_idle_a: assert property (clkEn && !st_q.on
        |=> st_q.state == adcs_pkg::ADCS_IDLE) else $error("ran while off");
    math_lag_a: assert property (clkEn && finish && mathDue
        |=> st_q.mathPend && st_q.err == $past(st_q.err))
        else $error("math not deferred");
    sleep_hold_a: assert property (clkEn && sleepMode && !st_q.cs &&
        st_q.state == adcs_pkg::ADCS_IDLE
        |=> st_q.state == adcs_pkg::ADCS_IDLE) else $error("sleep start");
    wake_req_a: assert property (clkEn && st_q.irqEn &&
        st_q.doneFlag |=> wakeReq) else $error("no wake request");
    apb_ready_a: assert property (clkEn && setup
        |=> pready ##1 !pready || !clkEn) else $error("ready timing");

endmodule : adcs_sequencer

// [core/adcs_defines.svh]
// Register offsets, field positions, reset values and counts of the sequencer.
`ifndef ADCS_DEFINES_SVH
`define ADCS_DEFINES_SVH

// ==========================================================================
// Register offsets
`define ADCS_OFF_CTRL     8'h00
`define ADCS_OFF_CLKDIV   8'h04
`define ADCS_OFF_STATUS   8'h08
`define ADCS_OFF_RESULT   8'h0C
`define ADCS_OFF_PREV     8'h10
`define ADCS_OFF_ACC      8'h14
`define ADCS_OFF_SETPOINT 8'h18
`define ADCS_OFF_THRESH   8'h1C
`define ADCS_OFF_ERROR    8'h20

// ==========================================================================
// Control register fields
`define ADCS_CTRL_ON      0
`define ADCS_CTRL_GO      1
`define ADCS_CTRL_CS      2
`define ADCS_CTRL_FRM     3
`define ADCS_CTRL_REPEAT_ENABLE    4
`define ADCS_CTRL_PREVIOUS_SOURCE_SELECT    5
`define ADCS_CTRL_DOUBLE_SAMPLE_ENABLE    6
`define ADCS_CTRL_IRQEN   7
`define ADCS_CTRL_TRIGEN  8

// ==========================================================================
// Status register fields
`define ADCS_ST_DONE      0
`define ADCS_ST_THR       1
`define ADCS_ST_MATH      2
`define ADCS_ST_BUSY      3
`define ADCS_ST_PEND      4
`define ADCS_ST_PDOWN     5

// ==========================================================================
// Reset values and counts
`define ADCS_CLKDIV_RST   7'h00
`define ADCS_SETPT_RST    12'h000
`define ADCS_THRESH_RST   13'h0000
`define ADCS_MSB_IDX      4'hB
`define ADCS_MSB_TRIAL    12'h800

`endif

// [core/adcs_pkg.sv]
// Types shared by the conversion sequencer modules.
package adcs_pkg;

    // ======================================================================
    // Sequencer states
    typedef enum logic [2:0] {
        ADCS_IDLE   = 3'b001,
        ADCS_SAMPLE = 3'b010,
        ADCS_CONV   = 3'b100
    } adcs_state_t;

    // ======================================================================
    // Whole state of the sequencer
    typedef struct packed {
        adcs_state_t  state;
        logic [3:0]   bitIdx;
        logic [11:0]  dac;
        logic         sampleHold;
        logic         on;
        logic         go;
        logic         cs;
        logic         result_justify_select;
        logic         repeat_enable;
        logic         previous_source_select;
        logic         double_sample_enable;
        logic         irqEn;
        logic         trigEn;
        logic [6:0]   clkDiv;
        logic         doneFlag;
        logic         thrFlag;
        logic         mathFlag;
        logic         trigPend;
        logic         powerDown;
        logic         pairOdd;
        logic         mathPend;
        logic [11:0]  res;
        logic [11:0]  prev;
        logic [11:0]  setpoint;
        logic [12:0]  thresh;
        logic [12:0]  err;
        logic [17:0]  acc;
        logic [2:0]   trigSync;
        logic [1:0]   cmpSync;
        logic [1:0]   rcSync;
        logic         pready;
        logic         pslverr;
        logic [31:0]  prdata;
        logic         wakeReq;
    } adcs_regs_t;

    // ======================================================================
    // Whole state of the conversion clock tick generator
    typedef struct packed {
        logic [7:0]   cnt;
        logic         rcPrev;
        logic         tick;
    } adcs_tick_t;

endpackage : adcs_pkg

// [core/adcs_tick_gen.sv]
// Conversion clock tick generator: system clock divider or RC oscillator edge.
`timescale 1ns/1ns
`include "adcs_defines.svh"

module adcs_tick_gen (
    input  wire logic       clk_sys,
    input  wire logic       sys_rst,
    input  wire logic       clkEn,
    input  wire logic       clkSel,
    input  wire logic [6:0] divCode,
    input  wire logic       rcLevel,
    output logic            tick
);

    adcs_pkg::adcs_tick_t st_q;
    adcs_pkg::adcs_tick_t st_d;

    // ======================================================================
    // Tick every 2*(n+1) system cycles, or on each rising oscillator edge
    always_comb begin
        st_d = st_q;
        st_d.tick = 1'b0;
        st_d.rcPrev = rcLevel;
        if (clkSel) begin
            st_d.cnt = 8'h00;
            st_d.tick = rcLevel & ~st_q.rcPrev;
        end else if (st_q.cnt >= {divCode, 1'b1}) begin
            st_d.cnt = 8'h00;
            st_d.tick = 1'b1;
        end else begin
            st_d.cnt = st_q.cnt + 8'h01;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            st_q <= '0;
        end else if (clkEn) begin
            st_q <= st_d;
        end
    end

    assign tick = st_q.tick;

endmodule : adcs_tick_gen

// [tb/adcs_analog_model.sv]
// Sample-and-hold and comparator that sit behind the sequencer.
`timescale 1ns/1ns

module adcs_analog_model (
    input  wire logic        clk_sys,
    input  wire logic        sampleHold,
    input  wire logic [11:0] dacCode,
    input  wire logic [11:0] vin,
    output logic             cmpOut
);
    logic [11:0] heldQ = 12'h000;

    // The held level follows the input only while the switch is closed.
    always_ff @(posedge clk_sys) begin
        if (sampleHold) begin
            heldQ <= vin;
        end
    end

    assign cmpOut = (heldQ >= dacCode);
endmodule : adcs_analog_model

// [tb/tb_top.sv]
// Self-checking bench of the conversion sequencer.
`timescale 1ns/1ns
`include "adcs_defines.svh"

module tb_top;
    logic        clk_sys   = 1'b0;
    logic        sys_rst   = 1'b1;
    logic        psel      = 1'b0;
    logic        penable   = 1'b0;
    logic        pwrite    = 1'b0;
    logic [7:0]  paddr     = 8'h00;
    logic [31:0] pwdata    = 32'h0000_0000;
    logic        extTrig   = 1'b0;
    logic        rcOscIn   = 1'b0;
    logic        sleepMode = 1'b0;
    logic [11:0] vin       = 12'h000;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        cmpOut;
    logic        sampleHold;
    logic [11:0] dacCode;
    logic        wakeReq;
    logic        powerDown;
    logic [31:0] rd;
    logic        err;
    int          rcCnt      = 0;
    int          mismatches = 0;
    int          n_checks   = 0;

    adcs_sequencer u_adcs_sequencer (.clk_sys(clk_sys), .sys_rst(sys_rst),
        .clkEn(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .extTrig(extTrig), .rcOscIn(rcOscIn),
        .cmpOut(cmpOut), .sleepMode(sleepMode), .sampleHold(sampleHold),
        .dacCode(dacCode), .wakeReq(wakeReq), .powerDown(powerDown));

    adcs_analog_model u_adcs_analog_model (.clk_sys(clk_sys),
        .sampleHold(sampleHold), .dacCode(dacCode), .vin(vin),
        .cmpOut(cmpOut));

    initial forever #4 clk_sys = ~clk_sys;

    // The RC oscillator runs free with a period of ten system clocks.
    always @(posedge clk_sys) begin
        rcCnt <= (rcCnt == 4) ? 0 : rcCnt + 1;
        if (rcCnt == 4) rcOscIn <= ~rcOscIn;
    end

    // ======================================================================
    // Shared tasks
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge clk_sys);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : bus

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask : wr

    task automatic rc(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0000_0000);
        check(rd, exp);
    endtask : rc

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
    endtask : cyc

    task automatic wdone();
        int k;
        k = 0;
        do begin
            bus(1'b0, `ADCS_OFF_STATUS, 32'h0000_0000);
            k++;
        end while (rd[`ADCS_ST_DONE] !== 1'b1 && k < 300);
        if (k >= 300) mismatches++;
    endtask : wdone

    task automatic trig();
        extTrig <= 1'b1;
        cyc(4);
        extTrig <= 1'b0;
    endtask : trig

    task automatic shFall(output int hi);
        int k;
        k = 0;
        hi = 0;
        while (sampleHold !== 1'b1 && k < 200) begin
            @(posedge clk_sys);
            k++;
        end
        while (sampleHold === 1'b1 && hi < 200) begin
            @(posedge clk_sys);
            hi++;
        end
    endtask : shFall

    task automatic start(input logic [11:0] v, input logic [31:0] c);
        vin <= v;
        wr(`ADCS_OFF_STATUS, 32'h0000_0007);
        wr(`ADCS_OFF_CTRL, c);
        wr(`ADCS_OFF_CTRL, c | 32'h0000_0002);
    endtask : start

    // ======================================================================
    // Scenarios
    task automatic t_reset();
        rc(`ADCS_OFF_CTRL, 32'h0000_0000);
        rc(`ADCS_OFF_STATUS, 32'h0000_0000);
        rc(`ADCS_OFF_CLKDIV, 32'h0000_0000);
        bus(1'b0, 8'h40, 32'h0000_0000);
        check(err, 1'b1);
    endtask : t_reset

    task automatic t_basic();
        wr(`ADCS_OFF_CLKDIV, 32'h0000_0001);
        start(12'hA5C, 32'h0000_0009);
        wdone();
        rc(`ADCS_OFF_RESULT, 32'h0000_0A5C);
        rc(`ADCS_OFF_CTRL, 32'h0000_0009);
        rc(`ADCS_OFF_ACC, 32'h0000_0A5C);
        cyc(100);
        rc(`ADCS_OFF_STATUS, 32'h0000_0007);
        wr(`ADCS_OFF_STATUS, 32'h0000_0001);
        rc(`ADCS_OFF_STATUS, 32'h0000_0006);
        wr(`ADCS_OFF_CTRL, 32'h0000_0001);
        rc(`ADCS_OFF_RESULT, 32'h0000_A5C0);
        wr(`ADCS_OFF_RESULT, 32'h0000_0123);
        rc(`ADCS_OFF_RESULT, 32'h0000_1230);
        wr(`ADCS_OFF_CTRL, 32'h0000_0009);
        rc(`ADCS_OFF_RESULT, 32'h0000_0123);
    endtask : t_basic

    task automatic t_prev();
        wr(`ADCS_OFF_SETPOINT, 32'h0000_0100);
        wr(`ADCS_OFF_THRESH, 32'h0000_0300);
        start(12'h3F0, 32'h0000_0029);
        wdone();
        rc(`ADCS_OFF_PREV, 32'h0000_0123);
        rc(`ADCS_OFF_RESULT, 32'h0000_03F0);
        rc(`ADCS_OFF_ERROR, 32'h0000_02F0);
        rc(`ADCS_OFF_STATUS, 32'h0000_0005);
        rc(`ADCS_OFF_ACC, 32'h0000_0E4C);
    endtask : t_prev

    task automatic t_div();
        int hi;
        wr(`ADCS_OFF_CLKDIV, 32'h0000_0003);
        start(12'h055, 32'h0000_0009);
        shFall(hi);
        check(32'(hi), 32'h0000_0008);
        wdone();
        rc(`ADCS_OFF_RESULT, 32'h0000_0055);
    endtask : t_div

    task automatic t_abort();
        int hi;
        wr(`ADCS_OFF_CLKDIV, 32'h0000_0007);
        start(12'h5A5, 32'h0000_0009);
        shFall(hi);
        // Drop the request after two bits, 0 then 1, have resolved.
        cyc(32);
        wr(`ADCS_OFF_CTRL, 32'h0000_0009);
        wdone();
        rc(`ADCS_OFF_RESULT, 32'h0000_07FF);
        start(12'h7FF, 32'h0000_0009);
        shFall(hi);
        wr(`ADCS_OFF_CTRL, 32'h0000_0008);
        cyc(300);
        rc(`ADCS_OFF_STATUS, 32'h0000_0000);
        wr(`ADCS_OFF_CLKDIV, 32'h0000_0001);
    endtask : t_abort

    task automatic t_sleep();
        wr(`ADCS_OFF_STATUS, 32'h0000_0007);
        wr(`ADCS_OFF_CTRL, 32'h0000_0189);
        sleepMode <= 1'b1;
        trig();
        cyc(200);
        rc(`ADCS_OFF_STATUS, 32'h0000_0010);
        sleepMode <= 1'b0;
        wdone();
        check(wakeReq, 1'b1);
        rc(`ADCS_OFF_CTRL, 32'h0000_0189);
        wr(`ADCS_OFF_STATUS, 32'h0000_0007);
        wr(`ADCS_OFF_CTRL, 32'h0000_018D);
        sleepMode <= 1'b1;
        trig();
        wdone();
        check(wakeReq, 1'b1);
        wr(`ADCS_OFF_STATUS, 32'h0000_0007);
        wr(`ADCS_OFF_CTRL, 32'h0000_010D);
        trig();
        wdone();
        check(powerDown, 1'b1);
        check(wakeReq, 1'b0);
        rc(`ADCS_OFF_CTRL, 32'h0000_010D);
        sleepMode <= 1'b0;
        cyc(3);
        check(powerDown, 1'b0);
    endtask : t_sleep

    task automatic t_pair();
        start(12'h200, 32'h0000_0059);
        wdone();
        rc(`ADCS_OFF_ERROR, 32'h0000_06FF);
        rc(`ADCS_OFF_CTRL, 32'h0000_005B);
        wr(`ADCS_OFF_STATUS, 32'h0000_0007);
        wdone();
        rc(`ADCS_OFF_ERROR, 32'h0000_0100);
        sys_rst <= 1'b1;
        cyc(2);
        sys_rst <= 1'b0;
        rc(`ADCS_OFF_CTRL, 32'h0000_0000);
        cyc(100);
        rc(`ADCS_OFF_STATUS, 32'h0000_0000);
        rc(`ADCS_OFF_RESULT, 32'h0000_0000);
    endtask : t_pair

    task automatic complete_run();
        $display("checks=%0d mismatches=%0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : complete_run

    initial begin
        cyc(5);
        sys_rst <= 1'b0;
        t_reset();
        t_basic();
        t_prev();
        t_div();
        t_abort();
        t_sleep();
        t_pair();
        complete_run();
    end

    initial begin
        cyc(60000);
        mismatches++;
        complete_run();
    end
endmodule : tb_top
